// *** pin_map_pkg.sv ***
package pin_map_pkg;

	// register map, byte addresses of 32-bit words
	localparam logic [7:0] CFG_CTRL_OFS   = 8'h00;
	localparam logic [7:0] NOTICE_OFS     = 8'h10;
	localparam logic [7:0] IN_SEL_OFS     = 8'h40;
	localparam logic [7:0] OUT_SEL_OFS    = 8'h80;

	// field positions and widths
	localparam int SEL_W          = 4;
	localparam int CFG_LOCK_BIT   = 13;
	localparam int NOTICE_ON_BIT    = 15;
	localparam int IDLE_STOP_BIT    = 13;
	localparam int NUM_NOTICE_PORTS = 3;

	// reset values
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic       BIT_RST = 1'b0;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** peripheral_pin_mapping.sv ***
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module peripheral_pin_mapping
	import pin_map_pkg::*;
#(
	parameter int NUM_PINS   = 8,
	parameter int NUM_IN_FN  = 8,
	parameter int NUM_OUT_FN = 8,
	// per code: pin index selected for a peripheral input
	parameter logic [15:0][7:0] IN_CODE_PIN  = '0,
	// per code: peripheral output index, an index of 0 leaves pin to port logic
	parameter logic [15:0][7:0] OUT_CODE_FN  = '0
) (
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	// axi4-lite slave
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output      logic                  s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output      logic                  s_axi_wready,
	output      logic [1:0]            s_axi_bresp,
	output      logic                  s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output      logic                  s_axi_arready,
	output      logic [31:0]           s_axi_rdata,
	output      logic [1:0]            s_axi_rresp,
	output      logic                  s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// pads and peripherals
	input  wire logic [NUM_PINS-1:0]   pin_in_i,
	output      logic [NUM_IN_FN-1:0]  periph_in_o,
	input  wire logic [NUM_OUT_FN-1:0] periph_out_i,
	output      logic [NUM_PINS-1:0]   pin_out_o,
	output      logic [NUM_PINS-1:0]   pin_mapped_o,
	// change notice
	input  wire logic                  idle_mode_i,
	output      logic [2:0]            change_notice_run_o
);

	logic [NUM_IN_FN-1:0][3:0]  in_sel_q;
	logic [NUM_PINS-1:0][3:0]   out_sel_q;
	logic [NUM_NOTICE_PORTS-1:0] notice_on_q;
	logic [NUM_NOTICE_PORTS-1:0] idle_stop_q;
	logic                       config_lock_bit_q;

	logic [7:0]  aw_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic        wr_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_d;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// address and data may arrive in either order; hold until both present
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_q      <= 8'h00;
			wd_q      <= 32'h0000_0000;
			ws_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_q <= 1'b0;
			end
		end
	end

	function automatic logic decode(input logic [7:0] a);
		decode = (a == CFG_CTRL_OFS)
			|| (a >= NOTICE_OFS && a < NOTICE_OFS + 8'(4 * NUM_NOTICE_PORTS))
			|| (a >= IN_SEL_OFS && a < IN_SEL_OFS + 8'(4 * NUM_IN_FN))
			|| (a >= OUT_SEL_OFS && a < OUT_SEL_OFS + 8'(4 * NUM_PINS));
	endfunction

	assign wr_hit = decode(aw_q);

	// register writes; only byte lanes that hold implemented bits matter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_sel_q          <= '0;
			out_sel_q         <= '0;
			notice_on_q       <= '0;
			idle_stop_q       <= '0;
			config_lock_bit_q <= BIT_RST;
		end else if (wr_go && wr_hit) begin
			if (aw_q == CFG_CTRL_OFS && ws_q[1]) begin
				config_lock_bit_q <= wd_q[CFG_LOCK_BIT];
			end
			for (int p = 0; p < NUM_NOTICE_PORTS; p++) begin
				if (aw_q == NOTICE_OFS + 8'(4 * p) && ws_q[1]) begin
					notice_on_q[p] <= wd_q[NOTICE_ON_BIT];
					idle_stop_q[p] <= wd_q[IDLE_STOP_BIT];
				end
			end
			for (int i = 0; i < NUM_IN_FN; i++) begin
				if (aw_q == IN_SEL_OFS + 8'(4 * i) && ws_q[0]
					&& !config_lock_bit_q) begin
					in_sel_q[i] <= wd_q[SEL_W-1:0];
				end
			end
			for (int n = 0; n < NUM_PINS; n++) begin
				if (aw_q == OUT_SEL_OFS + 8'(4 * n) && ws_q[0]
					&& !config_lock_bit_q) begin
					out_sel_q[n] <= wd_q[SEL_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read mux; unimplemented bits are never stored, so they read zero
	always_comb begin
		rd_d   = 32'h0000_0000;
		rd_hit = decode(s_axi_araddr);
		if (s_axi_araddr == CFG_CTRL_OFS) begin
			rd_d[CFG_LOCK_BIT] = config_lock_bit_q;
		end
		for (int p = 0; p < NUM_NOTICE_PORTS; p++) begin
			if (s_axi_araddr == NOTICE_OFS + 8'(4 * p)) begin
				rd_d[NOTICE_ON_BIT] = notice_on_q[p];
				rd_d[IDLE_STOP_BIT] = idle_stop_q[p];
			end
		end
		for (int i = 0; i < NUM_IN_FN; i++) begin
			if (s_axi_araddr == IN_SEL_OFS + 8'(4 * i)) begin
				rd_d[SEL_W-1:0] = in_sel_q[i];
			end
		end
		for (int n = 0; n < NUM_PINS; n++) begin
			if (s_axi_araddr == OUT_SEL_OFS + 8'(4 * n)) begin
				rd_d[SEL_W-1:0] = out_sel_q[n];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_d;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// routing, registered so data outputs come from flip-flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			periph_in_o  <= '0;
			pin_out_o    <= '0;
			pin_mapped_o <= '0;
		end else begin
			for (int i = 0; i < NUM_IN_FN; i++) begin
				periph_in_o[i] <= pin_in_i[IN_CODE_PIN[in_sel_q[i]]
					% NUM_PINS];
			end
			for (int n = 0; n < NUM_PINS; n++) begin
				pin_mapped_o[n] <= (OUT_CODE_FN[out_sel_q[n]] != 8'h00);
				pin_out_o[n]    <= periph_out_i[OUT_CODE_FN[out_sel_q[n]]
					% NUM_OUT_FN];
			end
		end
	end

	// change notice runs when enabled and not halted by idle
	always_comb begin
		for (int p = 0; p < NUM_NOTICE_PORTS; p++) begin
			change_notice_run_o[p] = notice_on_q[p]
				&& !(idle_stop_q[p] && idle_mode_i);
		end
	end

	property p_lock_holds_in_sel;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		config_lock_bit_q |=> $stable(in_sel_q);
	endproperty
	a_lock_holds_in_sel: assert property (p_lock_holds_in_sel)
		else $error("input select changed while locked");

	property p_lock_holds_out_sel;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		config_lock_bit_q |=> $stable(out_sel_q);
	endproperty
	a_lock_holds_out_sel: assert property (p_lock_holds_out_sel)
		else $error("output select changed while locked");

	property p_in_sel_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_go && !config_lock_bit_q && ws_q[0] && aw_q == IN_SEL_OFS
			|=> in_sel_q[0] == $past(wd_q[3:0]);
	endproperty
	a_in_sel_write: assert property (p_in_sel_write)
		else $error("input select write lost");

	property p_out_sel_write;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_go && !config_lock_bit_q && ws_q[0] && aw_q == OUT_SEL_OFS
			|=> out_sel_q[0] == $past(wd_q[3:0]);
	endproperty
	a_out_sel_write: assert property (p_out_sel_write)
		else $error("output select write lost");

	property p_sel_upper_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_axi_rvalid && s_axi_rresp == RESP_OKAY
			&& $past(s_axi_araddr) >= IN_SEL_OFS
			|-> s_axi_rdata[31:4] == 28'h0000000;
	endproperty
	a_sel_upper_zero: assert property (p_sel_upper_zero)
		else $error("select upper bits not zero");

	property p_notice_run;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!notice_on_q[0] |-> !change_notice_run_o[0];
	endproperty
	a_notice_run: assert property (p_notice_run)
		else $error("change notice runs while off");

	property p_notice_idle;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		notice_on_q[1] && idle_mode_i
			|-> change_notice_run_o[1] == !idle_stop_q[1];
	endproperty
	a_notice_idle: assert property (p_notice_idle)
		else $error("idle halt wrong");

	property p_notice_reserved;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_axi_rvalid && $past(s_axi_araddr) >= NOTICE_OFS
			&& $past(s_axi_araddr) < IN_SEL_OFS
			|-> (s_axi_rdata & 32'hFFFF_5FFF) == 32'h0000_0000;
	endproperty
	a_notice_reserved: assert property (p_notice_reserved)
		else $error("change notice reserved bits set");

	property p_notice_separate;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_go && aw_q == NOTICE_OFS |=> $stable(notice_on_q[2:1]);
	endproperty
	a_notice_separate: assert property (p_notice_separate)
		else $error("port A write touched other ports");

endmodule

// *** pin_pad_model.sv ***
`timescale 1ns/1ps

module pin_pad_model #(
	parameter int NUM_PINS   = 8,
	parameter int NUM_OUT_FN = 8
) (
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rst_n_i,
	// pad levels and peripheral outputs
	output      logic [NUM_PINS-1:0]   pin_in_o,
	output      logic [NUM_OUT_FN-1:0] periph_out_o
);
	// one hot level walks round, so each line has its own phase and a
	// wrong route shows up within one lap
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_in_o <= {{(NUM_PINS-1){1'b0}}, 1'b1};
		end else begin
			pin_in_o <= {pin_in_o[NUM_PINS-2:0], pin_in_o[NUM_PINS-1]};
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			periph_out_o <= {{(NUM_OUT_FN-1){1'b0}}, 1'b1};
		end else begin
			periph_out_o <= {periph_out_o[NUM_OUT_FN-2:0],
				periph_out_o[NUM_OUT_FN-1]};
		end
	end
endmodule

// *** test_peripheral_pin_mapping.sv ***
`timescale 1ns/1ps

module test_peripheral_pin_mapping;
	import pin_map_pkg::*;
	logic sys_clk_i = 0, rst_n_i = 0, idle_mode_i = 0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] pin_in_i, periph_in_o, periph_out_i, pin_out_o;
	logic [7:0] pin_mapped_o;
	logic [2:0] change_notice_run_o;
	int fails = 0, check_count = 0, cyc = 0;
	// code k: input from pin 7-(k mod 8), output from function k mod 8
	localparam logic [15:0][7:0] IN_TAB =
		128'h0001_0203_0405_0607_0001_0203_0405_0607;
	localparam logic [15:0][7:0] OUT_TAB =
		128'h0706_0504_0302_0100_0706_0504_0302_0100;
	logic [7:0] pin_prev, fn_prev;

	// the design registers its routes, so compare against last levels
	always @(posedge sys_clk_i) begin
		pin_prev <= pin_in_i;
		fn_prev <= periph_out_i;
	end

	always #50 sys_clk_i = ~sys_clk_i;

	peripheral_pin_mapping #(.IN_CODE_PIN(IN_TAB), .OUT_CODE_FN(OUT_TAB))
		uut (.sys_clk_i, .rst_n_i, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pin_in_i, .periph_in_o, .periph_out_i, .pin_out_o, .pin_mapped_o,
		.idle_mode_i, .change_notice_run_o);

	pin_pad_model pads (.sys_clk_i, .rst_n_i, .pin_in_o(pin_in_i),
		.periph_out_o(periph_out_i));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// a hung handshake is cut off here
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			finish_test();
		end
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ready is combinational, so it is looked at before the edge it meets
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic ta, tw, tb;
		tb = 0;
		@(posedge sys_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!tb) begin
			@(negedge sys_clk_i);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid === 1'b1;
			resp = s_axi_bresp;
			@(posedge sys_clk_i);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tb) s_axi_bready <= 0;
		end
		chk("bresp", 32'(er), 32'(resp));
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		tr = 0;
		@(posedge sys_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!tr) begin
			@(negedge sys_clk_i);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge sys_clk_i);
			if (ta) s_axi_arvalid <= 0;
			if (tr) s_axi_rready <= 0;
		end
		chk("rdata", e, d);
		chk("rresp", 32'(er), 32'(resp));
	endtask

	task automatic run_is(logic [2:0] e);
		@(negedge sys_clk_i);
		chk("notice_run", 32'(e), 32'(change_notice_run_o));
		@(posedge sys_clk_i);
	endtask

	// input function 1 and pin 2 over one lap of the walking pad level
	task automatic route_is(logic [3:0] ic, logic [3:0] oc);
		repeat (8) begin
			@(negedge sys_clk_i);
			chk("periph_in", 32'(pin_prev[IN_TAB[ic][2:0]]),
				32'(periph_in_o[1]));
			chk("pin_out", 32'(fn_prev[OUT_TAB[oc][2:0]]),
				32'(pin_out_o[2]));
			chk("pin_mapped", 32'(OUT_TAB[oc] != 8'h00),
				32'(pin_mapped_o[2]));
		end
	endtask

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1;
		rd(CFG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
		for (int p = 0; p < 3; p++) begin
			rd(NOTICE_OFS + 8'(4 * p), 32'h0000_0000, RESP_OKAY);
		end
		rd(IN_SEL_OFS + 8'h04, 32'h0000_0000, RESP_OKAY);
		rd(OUT_SEL_OFS + 8'h08, 32'h0000_0000, RESP_OKAY);
		route_is(4'h0, 4'h0);
		$display("reset values done");
		wr(IN_SEL_OFS + 8'h04, 32'hFFFF_FFFF, RESP_OKAY);
		rd(IN_SEL_OFS + 8'h04, 32'h0000_000F, RESP_OKAY);
		wr(OUT_SEL_OFS + 8'h08, 32'hFFFF_FFF6, RESP_OKAY);
		rd(OUT_SEL_OFS + 8'h08, 32'h0000_0006, RESP_OKAY);
		wr(IN_SEL_OFS + 8'h04, 32'h0000_0005, RESP_OKAY);
		rd(IN_SEL_OFS + 8'h04, 32'h0000_0005, RESP_OKAY);
		wr(IN_SEL_OFS, 32'h0000_0009, RESP_OKAY);
		rd(IN_SEL_OFS, 32'h0000_0009, RESP_OKAY);
		wr(OUT_SEL_OFS, 32'h0000_000A, RESP_OKAY);
		rd(OUT_SEL_OFS, 32'h0000_000A, RESP_OKAY);
		route_is(4'h5, 4'h6);
		$display("select fields done");
		wr(NOTICE_OFS, 32'hFFFF_FFFF, RESP_OKAY);
		rd(NOTICE_OFS, 32'h0000_A000, RESP_OKAY);
		rd(NOTICE_OFS + 8'h04, 32'h0000_0000, RESP_OKAY);
		run_is(3'b001);
		wr(NOTICE_OFS + 8'h04, 32'h0000_8000, RESP_OKAY);
		wr(NOTICE_OFS + 8'h08, 32'h0000_2000, RESP_OKAY);
		idle_mode_i <= 1;
		run_is(3'b010);
		idle_mode_i <= 0;
		run_is(3'b011);
		wr(NOTICE_OFS, 32'h0000_0000, RESP_OKAY);
		run_is(3'b010);
		$display("change notice done");
		wr(CFG_CTRL_OFS, 32'h0000_2000, RESP_OKAY);
		rd(CFG_CTRL_OFS, 32'h0000_2000, RESP_OKAY);
		wr(IN_SEL_OFS + 8'h04, 32'h0000_0003, RESP_OKAY);
		rd(IN_SEL_OFS + 8'h04, 32'h0000_0005, RESP_OKAY);
		wr(OUT_SEL_OFS + 8'h08, 32'h0000_0001, RESP_OKAY);
		rd(OUT_SEL_OFS + 8'h08, 32'h0000_0006, RESP_OKAY);
		wr(CFG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
		wr(IN_SEL_OFS + 8'h04, 32'h0000_0003, RESP_OKAY);
		rd(IN_SEL_OFS + 8'h04, 32'h0000_0003, RESP_OKAY);
		route_is(4'h3, 4'h6);
		$display("lock done");
		wr(8'hFC, 32'h0000_0001, RESP_SLVERR);
		rd(8'hFC, 32'h0000_0000, RESP_SLVERR);
		$display("unmapped done");
		finish_test();
	end
endmodule
